// [logic/rcirq_pkg.sv]
// Package for the radio core interrupt controller.
// Holds register offsets, field positions and reset values shared by the design.
package rcirq_pkg;
  // Register byte addresses
  localparam logic [31:0] RCIRQ_CTRL_ADDR = 32'h4000_000C; // interrupt_enable_control
  localparam logic [31:0] RCIRQ_MSTAT_ADDR = 32'h4000_0010; // interrupt_masked_status
  localparam logic [31:0] RCIRQ_RAW_ADDR = 32'h4000_0014; // interrupt_raw_status
  localparam logic [31:0] RCIRQ_ACK_ADDR = 32'h4000_0018; // Write-1 acknowledge
  // Source count and field positions
  localparam int RCIRQ_NSRC = 9; // Number of interrupt sources
  localparam int RCIRQ_SEL_LSB = 16; // slot_count_select low bit
  localparam int RCIRQ_SEL_W = 16; // slot_count_select width
  localparam int RCIRQ_DEV_BIT = 15; // tick_during_event_enable
  localparam int RCIRQ_TICK_BIT = 0; // Base tick source position
  // Control reset value and writable bits
  localparam logic [31:0] RCIRQ_CTRL_RST = 32'h00FF_801F; // Select FF, bit 15, low enables
  localparam logic [31:0] RCIRQ_CTRL_WMASK = 32'hFFFF_81FF; // Bits 14:9 reserved
  localparam logic [8:0] RCIRQ_FLAG_RST = 9'h000; // Flags clear at reset
  localparam logic [31:0] RCIRQ_ZERO = 32'h0000_0000; // Unmapped read value
  // AHB encodings
  localparam logic [1:0] RCIRQ_HTRANS_NONSEQ = 2'h2; // Non-sequential transfer
  localparam logic RCIRQ_HRESP_OKAY = 1'h0; // Only response used
endpackage

// [logic/rcirq_top.sv]
// Interrupt mask and status logic of the radio link-layer core, AHB-Lite slave.
// Assumes event pulses, slot counter and event level come from logic on sys_clk_i.
// Summary of operation
// [R1] Selected slot counter values raise base tick
// [R2] Bit 15 low suppresses tick during events
// [R3] Control bits 8:0 enable each source
// [R4] Enable reset values; bits 14:9 read zero
// [R5] Masked status is raw AND enable
// [R6] Masked bits 5..0 follow enable layout
// [R7] Masked bits 8,7,6 radio, fine, gross
// [R8] Raw status ignores enables, resets zero
// [R9] Writing one acknowledges raw and masked flag
// [R10] Interrupt output is level, held until acknowledged or its enable is cleared
// [R11] Interrupt line is OR of masked bits
`timescale 1ns/1ps
module rcirq_top
  import rcirq_pkg::*;
#(
  parameter int SLOT_W = 4 // Slot counter width
) (
  input wire logic sys_clk_i, // System clock, 10 MHz
  input wire logic arst_n_i, // Asynchronous reset, active low
  input wire logic hsel_i, // AHB slave select
  input wire logic [31:0] haddr_i, // AHB address
  input wire logic [1:0] htrans_i, // AHB transfer type
  input wire logic hwrite_i, // AHB write flag
  input wire logic [2:0] hsize_i, // AHB size, word only
  input wire logic [31:0] hwdata_i, // AHB write data
  input wire logic hready_i, // AHB bus ready
  output logic [31:0] hrdata_o, // AHB read data
  output logic hreadyout_o, // AHB slave ready
  output logic hresp_o, // AHB response, always OKAY
  input wire logic [7:0] src_event_i, // Event pulses for sources 8..1
  input wire logic [SLOT_W-1:0] slot_count_i, // Current slot counter value
  input wire logic slot_tick_i, // Pulse when slot counter advances
  input wire logic radio_event_i, // High during radio events
  output logic irq_o // Level interrupt to processor
);

  // Select field must cover every slot counter value
  if ((1 << SLOT_W) != RCIRQ_SEL_W) begin : g_bad_slot_w
    $error("SLOT_W must give one select bit per counter value");
  end

  // Address match helper used by several decoders
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  logic [31:0] ctrl_reg; // interrupt_enable_control
  logic [31:0] ctrl_next; // Next control value
  logic [8:0] raw_reg; // Raw pending flags
  logic [8:0] raw_next; // Next raw flags
  logic [31:0] hrdata_reg; // Read data register
  logic [31:0] hrdata_next; // Next read data
  logic hreadyout_reg; // Ready register
  logic hresp_reg; // Response register, always OKAY
  logic irq_reg; // Interrupt output register
  logic wr_pend_reg; // Write data phase pending
  logic [31:0] wr_addr_reg; // Address of pending write

  // Address phase decode
  wire addr_phase = hsel_i && (htrans_i == RCIRQ_HTRANS_NONSEQ) && hready_i;
  wire rd_take = addr_phase && !hwrite_i;
  wire wr_take = addr_phase && hwrite_i;
  // Data phase write strobes
  wire ctrl_wr = wr_pend_reg && addr_hit(wr_addr_reg, RCIRQ_CTRL_ADDR);
  wire ack_wr = wr_pend_reg && addr_hit(wr_addr_reg, RCIRQ_ACK_ADDR);
  wire [8:0] ack_bits = ack_wr ? hwdata_i[8:0] : RCIRQ_FLAG_RST;

  // Control write keeps reserved bits at zero
  assign ctrl_next = ctrl_wr ? (hwdata_i & RCIRQ_CTRL_WMASK) : ctrl_reg; // R4

  // Base tick generation from selected slot values
  wire [RCIRQ_SEL_W-1:0] slot_sel = ctrl_reg[RCIRQ_SEL_LSB +: RCIRQ_SEL_W];
  wire tick_sel_hit = slot_tick_i && slot_sel[slot_count_i]; // R1
  wire tick_allowed = !radio_event_i || ctrl_reg[RCIRQ_DEV_BIT]; // R2
  wire tick_set = tick_sel_hit && tick_allowed; // R1 R2
  wire [8:0] set_vec = {src_event_i, tick_set};
  wire [8:0] en_vec = ctrl_reg[8:0]; // R3
  wire [8:0] en_next = ctrl_next[8:0];

  // Per-source flag: a new event wins over an acknowledge in the same cycle
  for (genvar i = 0; i < RCIRQ_NSRC; i++) begin : g_flag
    assign raw_next[i] = set_vec[i] || (raw_reg[i] && !ack_bits[i]); // R8 R9
  end

  // Masked view, laid out like the enables
  wire [8:0] mstat_next = raw_next & en_next; // R5 R6 R7
  wire [8:0] mstat_now = raw_reg & en_vec; // R5

  // Read data mux, using post-edge values so writes are seen at once
  wire rd_ctrl = addr_hit(haddr_i, RCIRQ_CTRL_ADDR);
  wire rd_mstat = addr_hit(haddr_i, RCIRQ_MSTAT_ADDR);
  wire rd_raw = addr_hit(haddr_i, RCIRQ_RAW_ADDR);
  assign hrdata_next = !rd_take ? RCIRQ_ZERO :
                       rd_ctrl ? ctrl_next :
                       rd_mstat ? {23'h000000, mstat_next} : // R5
                       rd_raw ? {23'h000000, raw_next} : // R8
                       RCIRQ_ZERO;

  // Control register
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= RCIRQ_CTRL_RST; // R4
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Raw flags and level interrupt output
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      raw_reg <= RCIRQ_FLAG_RST; // R8
      irq_reg <= 1'h0;
    end else begin
      raw_reg <= raw_next; // R9
      irq_reg <= |mstat_next; // R10 R11
    end
  end

  // Bus write capture and read data
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pend_reg <= 1'h0;
      wr_addr_reg <= RCIRQ_ZERO;
      hrdata_reg <= RCIRQ_ZERO;
      hreadyout_reg <= 1'h1;
      hresp_reg <= RCIRQ_HRESP_OKAY;
    end else begin
      wr_pend_reg <= wr_take;
      wr_addr_reg <= wr_take ? haddr_i : wr_addr_reg;
      hrdata_reg <= hrdata_next;
      hreadyout_reg <= 1'h1; // Zero wait states
      hresp_reg <= RCIRQ_HRESP_OKAY; // No error responses
    end
  end

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = hresp_reg;
  assign irq_o = irq_reg;

  // Helper: control untouched since reset
  logic ctrl_fresh_reg; // No control write yet
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_fresh_reg <= 1'h1;
    end else begin
      ctrl_fresh_reg <= ctrl_fresh_reg && !ctrl_wr;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Sequences for a bus read of a given register
  sequence read_mstat_s;
    rd_take && rd_mstat;
  endsequence
  sequence read_raw_s;
    rd_take && rd_raw;
  endsequence
  sequence read_ctrl_s;
    rd_take && rd_ctrl;
  endsequence
  sequence read_ack_s;
    rd_take && addr_hit(haddr_i, RCIRQ_ACK_ADDR);
  endsequence

  // Line follows masked status every cycle
  irq_or_a: assert property (irq_o == |mstat_now) // R11
    else $error("irq_o differs from OR of masked flags");

  // Masked read returns raw AND enables
  mstat_read_a: assert property (read_mstat_s |=> hrdata_o == {23'h000000, raw_reg & en_vec}) // R5
    else $error("masked status read wrong");

  // Raw read ignores enables
  raw_read_a: assert property (read_raw_s |=> hrdata_o == {23'h000000, raw_reg}) // R8
    else $error("raw status read wrong");

  // Every event pulse sets its raw flag
  raw_set_a: assert property (|set_vec |=> (raw_reg & $past(set_vec)) == $past(set_vec)) // R8
    else $error("event did not set raw flag");

  // Acknowledge clears flags without a coinciding event
  ack_clear_a: assert property ((ack_bits & ~set_vec) != 9'h000
      |=> (raw_reg & $past(ack_bits & ~set_vec)) == 9'h000) // R9
    else $error("acknowledge did not clear flag");

  // Level held until acknowledge or enable change
  level_hold_a: assert property (irq_o && !wr_pend_reg |=> irq_o) // R10
    else $error("interrupt dropped without acknowledge");

  // Unselected slot values raise no tick
  tick_unsel_a: assert property (slot_tick_i && !slot_sel[slot_count_i] && !raw_reg[0]
      |=> !raw_reg[0]) // R1
    else $error("tick raised on unselected slot");

  // Selected slot value outside events raises tick
  tick_sel_a: assert property (slot_tick_i && slot_sel[slot_count_i] && !radio_event_i
      |=> raw_reg[0]) // R1
    else $error("tick missing on selected slot");

  // Tick suppressed during events when bit 15 is clear
  event_block_a: assert property (slot_tick_i && radio_event_i && !ctrl_reg[RCIRQ_DEV_BIT]
      && !raw_reg[0] |=> !raw_reg[0]) // R2
    else $error("tick raised during event");

  // Reset values hold until first control write
  ctrl_reset_a: assert property (ctrl_fresh_reg |-> ctrl_reg == RCIRQ_CTRL_RST) // R4
    else $error("control reset value wrong");

  // Reserved control bits stay zero
  ctrl_rsvd_a: assert property ((ctrl_reg & ~RCIRQ_CTRL_WMASK) == RCIRQ_ZERO) // R4
    else $error("reserved control bits set");

  // Disabled source never reaches the line alone
  en_gate_a: assert property ((raw_reg & en_vec) == 9'h000 |-> !irq_o) // R3 R6 R7
    else $error("disabled source drove interrupt");

  // Control read returns the value just written or held
  ctrl_read_a: assert property (read_ctrl_s |=> hrdata_o == ctrl_reg) // R4
    else $error("control read wrong");

  // Acknowledge register reads back as zero
  ack_read_a: assert property (read_ack_s |=> hrdata_o == RCIRQ_ZERO) // R9
    else $error("acknowledge read not zero");

  // No read taken leaves the read data at zero
  idle_zero_a: assert property (!rd_take |=> hrdata_o == RCIRQ_ZERO) // R5
    else $error("read data not zero outside a read");

  // Enabled event raises the line at the next edge
  irq_rise_a: assert property ((set_vec & en_next) != 9'h000 |=> irq_o) // R10 R11
    else $error("enabled event did not raise interrupt");

  // New event wins over an acknowledge in the same cycle
  set_wins_a: assert property ((set_vec & ack_bits) != 9'h000
      |=> (raw_reg & $past(set_vec & ack_bits)) == $past(set_vec & ack_bits)) // R9
    else $error("acknowledge beat coinciding event");

  // Without acknowledge every flag holds
  raw_hold_a: assert property (ack_bits == 9'h000
      |=> (raw_reg & $past(raw_reg)) == $past(raw_reg)) // R10
    else $error("flag dropped without acknowledge");

  // A flag only rises on its own event
  raw_new_a: assert property ((raw_reg & ~$past(raw_reg) & ~$past(set_vec)) == 9'h000) // R8
    else $error("flag rose without event");

  // Tick allowed during events when bit 15 is set
  event_allow_a: assert property (slot_tick_i && slot_sel[slot_count_i] && radio_event_i
      && ctrl_reg[RCIRQ_DEV_BIT] |=> raw_reg[0]) // R2
    else $error("tick missing during event");

  // No tick source leaves the base tick flag clear
  tick_quiet_a: assert property (!tick_set && !raw_reg[0] |=> !raw_reg[0]) // R1
    else $error("base tick flag rose without tick");

  // Control write stores the data with reserved bits cleared
  ctrl_write_a: assert property (ctrl_wr
      |=> ctrl_reg == ($past(hwdata_i) & RCIRQ_CTRL_WMASK)) // R3
    else $error("control write not stored");

  // Control holds when not written
  ctrl_keep_a: assert property (!ctrl_wr |=> $stable(ctrl_reg)) // R3
    else $error("control changed without write");

  // Acknowledge bits only act in an acknowledge data phase
  ack_only_a: assert property (!ack_wr |-> ack_bits == 9'h000) // R9
    else $error("acknowledge active outside write");

  // Acknowledging the last pending source drops the line
  ack_drop_a: assert property (ack_wr && set_vec == 9'h000
      && (mstat_now & ~ack_bits) == 9'h000 |=> !irq_o) // R9 R10
    else $error("interrupt stayed after acknowledge");

  // Nothing pending and enabled keeps the line low
  irq_low_a: assert property ((raw_next & en_next) == 9'h000 |=> !irq_o) // R3
    else $error("interrupt without enabled source");

  // Masked read never shows a disabled source
  mstat_en_a: assert property (read_mstat_s |=> (hrdata_o[8:0] & ~en_vec) == 9'h000) // R3 R5
    else $error("masked read shows disabled source");

  // Raw read keeps reserved bits at zero
  raw_rsvd_a: assert property (read_raw_s |=> hrdata_o[31:9] == 23'h000000) // R8
    else $error("raw read reserved bits set");

  // Line high means an enabled flag is pending
  irq_cause_a: assert property (irq_o |-> (raw_reg & en_vec) != 9'h000) // R10
    else $error("interrupt without pending flag");

endmodule // rcirq_top

// [test/rcirq_src_model.sv]
// Model of the event sources that sit beside the interrupt controller.
// Assumes the caller enters its task just after a rising clock edge.
`timescale 1ns/1ps
module rcirq_src_model #(
  parameter int SLOT_W = 4 // Slot counter width
) (
  input wire logic sys_clk_i, // System clock
  output logic [7:0] src_event_o, // Event pulses, sources 8..1
  output logic [SLOT_W-1:0] slot_count_o, // Slot counter value
  output logic slot_tick_o, // Slot counter advance pulse
  output logic radio_event_o // Radio event level
);
  // Quiet sources at time zero
  initial begin
    src_event_o = 8'h00;
    slot_count_o = '0;
    slot_tick_o = 1'b0;
    radio_event_o = 1'b0;
  end
  // Raise pulses for one cycle, counter value is held afterwards
  task automatic fire(input logic [7:0] ev, input logic [SLOT_W-1:0] cnt,
                      input logic tk, input logic rev);
    src_event_o <= ev;
    slot_count_o <= cnt;
    slot_tick_o <= tk;
    radio_event_o <= rev;
    @(posedge sys_clk_i);
    src_event_o <= 8'h00;
    slot_tick_o <= 1'b0;
    radio_event_o <= 1'b0;
  endtask
endmodule // rcirq_src_model

// [test/radio_core_interrupt_ctrl_tb.sv]
// Self-checking bench: AHB-Lite register accesses and source events.
// Assumes zero wait state slave; hready is fed back from hreadyout.
`timescale 1ns/1ps
module radio_core_interrupt_ctrl_tb;
  import rcirq_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0; // Bus controls
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q; // Bus data
  logic [1:0] htrans = 2'h0; // Transfer type
  logic hresp, irq; // Design outputs
  wire logic hready; // Bus ready
  wire logic [7:0] ev; // Event pulses
  wire logic [3:0] cnt; // Slot counter
  wire logic tick, rev; // Tick and event level
  int errors = 0, n_checks = 0; // Counters
  // Clock of 100 ns period
  always #50 clk = ~clk;
  rcirq_top #(.SLOT_W(4)) uut (.sys_clk_i(clk), .arst_n_i(arst_n), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .src_event_i(ev), .slot_count_i(cnt), .slot_tick_i(tick),
    .radio_event_i(rev), .irq_o(irq));
  rcirq_src_model #(.SLOT_W(4)) src (.sys_clk_i(clk), .src_event_o(ev),
    .slot_count_o(cnt), .slot_tick_o(tick), .radio_event_o(rev));
  // Report verdict and stop
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One AHB single transfer; values settle before the sampling edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    logic rdy;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= RCIRQ_HTRANS_NONSEQ;
    do begin @(negedge clk); rdy = hready; @(posedge clk); end while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(negedge clk); rdy = hready; r = hrdata; @(posedge clk); end
    while (rdy !== 1'b1);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Check the interrupt line between edges
  task automatic chk_irq(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(RCIRQ_CTRL_ADDR, 32'h00FF_801F);
    rd(RCIRQ_MSTAT_ADDR, 32'h0000_0000);
    rd(RCIRQ_RAW_ADDR, 32'h0000_0000);
    wr(RCIRQ_CTRL_ADDR, 32'hFFFF_FFFF);
    rd(RCIRQ_CTRL_ADDR, 32'hFFFF_81FF);
    wr(RCIRQ_CTRL_ADDR, 32'h0000_0000);
    src.fire(8'hFF, 4'h0, 1'b0, 1'b0);
    rd(RCIRQ_RAW_ADDR, 32'h0000_01FE);
    rd(RCIRQ_MSTAT_ADDR, 32'h0000_0000);
    chk_irq(1'b0);
    wr(RCIRQ_ACK_ADDR, 32'h0000_01FF);
    rd(RCIRQ_RAW_ADDR, 32'h0000_0000);
    // Sources 1 to 8 alone, held until acknowledged
    for (int i = 1; i < 9; i++) begin
      wr(RCIRQ_CTRL_ADDR, 32'h1 << i);
      src.fire(8'(9'h1 << (i - 1)), 4'h0, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      chk_irq(1'b1);
      rd(RCIRQ_MSTAT_ADDR, 32'h1 << i);
      wr(RCIRQ_ACK_ADDR, 32'h1 << i);
      chk_irq(1'b0);
      rd(RCIRQ_RAW_ADDR, 32'h0000_0000);
    end
    // Base tick: select slot 3, suppressed during events unless bit 15 is set
    wr(RCIRQ_CTRL_ADDR, 32'h0008_0001);
    src.fire(8'h00, 4'h3, 1'b1, 1'b1);
    rd(RCIRQ_RAW_ADDR, 32'h0000_0000);
    src.fire(8'h00, 4'h2, 1'b1, 1'b0);
    rd(RCIRQ_RAW_ADDR, 32'h0000_0000);
    src.fire(8'h00, 4'h3, 1'b1, 1'b0);
    rd(RCIRQ_MSTAT_ADDR, 32'h0000_0001);
    wr(RCIRQ_ACK_ADDR, 32'h0000_0001);
    wr(RCIRQ_CTRL_ADDR, 32'h0008_8001);
    src.fire(8'h00, 4'h3, 1'b1, 1'b1);
    rd(RCIRQ_RAW_ADDR, 32'h0000_0001);
    rd(32'h4000_0020, RCIRQ_ZERO);
    // Reset in mid-run restores defaults
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(RCIRQ_RAW_ADDR, 32'h0000_0000);
    rd(RCIRQ_CTRL_ADDR, 32'h00FF_801F);
    test_done;
  end
  // Watchdog, far beyond the roughly 170 cycles expected
  initial begin
    #500000;
    errors++;
    test_done;
  end
endmodule // radio_core_interrupt_ctrl_tb
